// ---- hdl/sbc_branch_ctrl.v ----
`timescale 1ns/1ps
`include "sbc_defs.vh"
module sbc_branch_ctrl #(
	parameter NIRQ  = 8,
	parameter NCOND = 4
) (
	input  wire             core_clk,
	input  wire             arst_n,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [11:0]      paddr,
	input  wire [31:0]      pwdata,
	output wire             pready,
	output reg  [31:0]      prdata,
	output wire             pslverr,
	input  wire [3:0]       external_irq_pins,
	input  wire [NIRQ-1:0]  internal_irq,
	output reg  [31:0]      fetch_pc,
	output reg              flush,
	output reg  [2:0]       slot_exec,
	output reg              xfer_x_we,
	output reg              xfer_y_we
);
	localparam ST_IDLE = 3'b001;
	localparam ST_EXEC = 3'b010;
	localparam ST_FIX  = 3'b100;

	reg  [2:0]      state_reg;
	reg  [31:0]     ctrl_reg;
	reg  [31:0]     ext_reg;
	reg  [31:0]     ctgt_reg;
	reg  [31:0]     integer_unit_reg;
	reg  [NIRQ-1:0] sw_latch_reg;
	reg  [NIRQ-1:0] pend_reg;
	reg  [2*NCOND-1:0] flags_reg;
	reg  [7:0]      status_reg;
	reg  [31:0]     ret_pc_reg;
	reg  [31:0]     fix_pc_reg;
	reg  [31:0]     target;
	reg             legal;

	wire            wr_en;
	wire            rd_en;
	wire [2:0]      kind;
	wire            np;
	wire            fixed_target_flag;
	wire            wide;
	wire            cond_true;
	wire            go_exec;
	wire            branch_kind;
	wire            taken;
	wire            mispredict;
	wire [31:0]     imm_val;
	wire [31:0]     seq_pc;
	wire [NIRQ-1:0] priority_mask_reg;
	wire [NIRQ-1:0] svc_onehot;
	wire [NIRQ-1:0] block_mask;
	wire [NIRQ-1:0] irq_all;
	wire [NIRQ-1:0] irq_ok;
	wire            irq_enter;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	assign kind              = ctrl_reg[`SBC_C_KIND];
	assign np                = ctrl_reg[`SBC_C_NP];
	assign fixed_target_flag = ctrl_reg[`SBC_C_ABS];
	assign wide              = ctrl_reg[`SBC_C_WIDE];
	assign go_exec = wr_en & (paddr == `SBC_A_CTRL);
	assign seq_pc  = fetch_pc + `SBC_PC_STEP;

	sbc_cond_eval #(
		.NCOND (NCOND)
	) u_cond (
		.x_flags   (flags_reg[NCOND-1:0]),
		.y_flags   (flags_reg[2*NCOND-1:NCOND]),
		.csel      (ctrl_reg[`SBC_C_CSEL]),
		.blk       (ctrl_reg[`SBC_C_BLK]),
		.use_cond  (ctrl_reg[`SBC_C_COND]),
		.cond_true (cond_true)
	);

	// Wide form takes extension word; 16-bit form: sign or zero extend
	assign imm_val = wide ? ext_reg :
		(fixed_target_flag ? {16'h0000, ctrl_reg[`SBC_C_IMM]} :
		{{16{ctrl_reg[31]}}, ctrl_reg[`SBC_C_IMM]});

	assign branch_kind = (kind != `SBC_K_NONE) & (kind != `SBC_K_REDUCE);
	// Condition inverted selects the else-governed slots
	assign taken      = branch_kind & cond_true & legal;
	assign mispredict = branch_kind & legal & (taken == np);

	always @* begin
		legal = 1'b1;
		case (kind)
		`SBC_K_CCALL: legal = np | fixed_target_flag;
		`SBC_K_RETURN_REUSABLE,
		`SBC_K_RTI:   legal = fixed_target_flag;
		default:      legal = ~(wide & ctrl_reg[`SBC_C_SLOT]);
		endcase
	end

	always @* begin
		case (kind)
		`SBC_K_CJMP,
		`SBC_K_CCALL: target = ctgt_reg;
		`SBC_K_RETURN_REUSABLE,
		`SBC_K_RTI:   target = ret_pc_reg;
		default:      target = fixed_target_flag ? imm_val :
			fetch_pc + imm_val;
		endcase
	end

	assign irq_all   = internal_irq | sw_latch_reg |
		{{(NIRQ-4){1'b0}}, external_irq_pins};
	assign irq_ok    = pend_reg & ~block_mask;
	assign irq_enter = (state_reg == ST_IDLE) & (|irq_ok) & ~go_exec;

	sbc_prio_mask #(
		.NIRQ (NIRQ)
	) u_mask (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.irq_req           (irq_ok),
		.enter             (irq_enter),
		.leave             (state_reg == ST_EXEC & taken &
			(kind == `SBC_K_RTI | kind == `SBC_K_RETURN_REUSABLE)),
		.reduce            (state_reg == ST_EXEC & legal & cond_true &
			kind == `SBC_K_REDUCE),
		.priority_mask_reg (priority_mask_reg),
		.svc_onehot_reg    (svc_onehot),
		.block_mask        (block_mask)
	);

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg    <= ST_IDLE;
			ctrl_reg     <= 32'h0000_0000;
			ext_reg      <= 32'h0000_0000;
			ctgt_reg     <= `SBC_CTGT_RST;
			integer_unit_reg     <= 32'h0000_0000;
			sw_latch_reg <= {NIRQ{1'b0}};
			pend_reg     <= {NIRQ{1'b0}};
			flags_reg    <= {2*NCOND{1'b0}};
			status_reg   <= 8'h00;
			ret_pc_reg   <= `SBC_RESET_PC;
			fix_pc_reg   <= `SBC_RESET_PC;
			fetch_pc     <= `SBC_RESET_PC;
			flush        <= 1'b0;
			slot_exec    <= 3'h0;
			xfer_x_we    <= 1'b0;
			xfer_y_we    <= 1'b0;
		end else begin
			flush     <= 1'b0;
			slot_exec <= 3'h0;
			xfer_x_we <= 1'b0;
			xfer_y_we <= 1'b0;
			// Incoming request set wins over the clear on interrupt entry
			pend_reg <= (pend_reg & ~(irq_enter ? irq_ok & ~(irq_ok - 1'b1)
				: {NIRQ{1'b0}})) | irq_all;
			if (wr_en) begin
				case (paddr)
				`SBC_A_CTRL:  ctrl_reg <= pwdata;
				`SBC_A_PC:    ext_reg <= pwdata;
				`SBC_A_INTEGER_UNIT:  ctgt_reg <= pwdata;
				`SBC_A_IRQ:   sw_latch_reg <= pwdata[NIRQ-1:0];
				`SBC_A_FLAGS: flags_reg <= pwdata[2*NCOND-1:0];
				`SBC_A_CTGT:  ctgt_reg <= pwdata;
				default:      integer_unit_reg <= integer_unit_reg;
				endcase
			end
			if (wr_en & paddr == `SBC_A_INTEGER_UNIT)
				integer_unit_reg <= pwdata;
			case (state_reg)
			ST_IDLE: begin
				if (go_exec)
					state_reg <= ST_EXEC;
				else if (irq_enter) begin
					ret_pc_reg <= fetch_pc;
					fetch_pc   <= `SBC_IRQ_VEC;
					status_reg[`SBC_S_INSVC] <= 1'b1;
					status_reg[`SBC_S_REDUCED] <= 1'b0;
				end
			end
			ST_EXEC: begin
				status_reg[`SBC_S_TAKEN]   <= taken;
				status_reg[`SBC_S_MISP]    <= mispredict;
				status_reg[`SBC_S_ILLEGAL] <= ~legal;
				// Governed slots follow condition, others always run
				slot_exec <= ~ctrl_reg[`SBC_C_GOV] |
					(cond_true ^ ctrl_reg[`SBC_C_INV] ?
					3'h7 : 3'h0);
				if (kind == `SBC_K_NONE) begin
					xfer_x_we <= ctrl_reg[`SBC_C_BLK] != `SBC_B_Y;
					xfer_y_we <= ctrl_reg[`SBC_C_BLK] != `SBC_B_X;
				end
				if (kind == `SBC_K_REDUCE & legal & cond_true)
					status_reg[`SBC_S_REDUCED] <= 1'b1;
				if (kind == `SBC_K_RTI & taken)
					status_reg[`SBC_S_NEEDREU] <=
						status_reg[`SBC_S_REDUCED];
				if (taken & (kind == `SBC_K_CALL | kind == `SBC_K_CCALL))
					ctgt_reg <= seq_pc;
				if (taken & (kind == `SBC_K_RTI | kind == `SBC_K_RETURN_REUSABLE))
					status_reg[`SBC_S_INSVC] <= 1'b0;
				fix_pc_reg <= taken ? target : seq_pc;
				if (mispredict) begin
					flush     <= 1'b1;
					state_reg <= ST_FIX;
				end else begin
					fetch_pc  <= taken ? target : seq_pc;
					state_reg <= ST_IDLE;
				end
			end
			ST_FIX: begin
				fetch_pc  <= fix_pc_reg;
				state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			prdata <= 32'h0000_0000;
		else if (rd_en & ~penable) begin
			case (paddr)
			`SBC_A_CTRL:   prdata <= ctrl_reg;
			`SBC_A_PC:     prdata <= fetch_pc;
			`SBC_A_CTGT:   prdata <= ctgt_reg;
			`SBC_A_INTEGER_UNIT:   prdata <= integer_unit_reg;
			`SBC_A_PRIORITY_MASK_REG:  prdata <= {{(32-NIRQ){1'b0}}, priority_mask_reg};
			`SBC_A_IRQ:    prdata <= {{(32-NIRQ){1'b0}}, pend_reg};
			`SBC_A_FLAGS:  prdata <= {{(32-2*NCOND){1'b0}}, flags_reg};
			`SBC_A_STATUS: prdata <= {24'h000000, status_reg};
			`SBC_A_RESULT: prdata <= {{(32-NIRQ){1'b0}}, svc_onehot};
			default:       prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // sbc_branch_ctrl

// ---- hdl/sbc_defs.vh ----
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH
// APB register byte addresses
`define SBC_A_CTRL     12'h000
`define SBC_A_PC       12'h004
`define SBC_A_CTGT     12'h008
`define SBC_A_INTEGER_UNIT     12'h00c
`define SBC_A_PRIORITY_MASK_REG    12'h010
`define SBC_A_IRQ      12'h014
`define SBC_A_FLAGS    12'h018
`define SBC_A_STATUS   12'h01c
`define SBC_A_RESULT   12'h020
// Branch kind codes
`define SBC_K_NONE     3'h0
`define SBC_K_JUMP     3'h1
`define SBC_K_CALL     3'h2
`define SBC_K_CJMP     3'h3
`define SBC_K_CCALL    3'h4
`define SBC_K_RETURN_REUSABLE     3'h5
`define SBC_K_RTI      3'h6
`define SBC_K_REDUCE   3'h7
// Control word fields
`define SBC_C_KIND     2:0
`define SBC_C_NP       3
`define SBC_C_ABS      4
`define SBC_C_COND     5
`define SBC_C_BLK      7:6
`define SBC_C_CSEL     9:8
`define SBC_C_INV      10
`define SBC_C_GOV      13:11
`define SBC_C_WIDE     14
`define SBC_C_SLOT     15
`define SBC_C_IMM      31:16
// Block select
`define SBC_B_BOTH     2'h0
`define SBC_B_X        2'h1
`define SBC_B_Y        2'h2
// Status bits
`define SBC_S_TAKEN    0
`define SBC_S_MISP     1
`define SBC_S_ILLEGAL  2
`define SBC_S_INSVC    3
`define SBC_S_REDUCED  4
`define SBC_S_NEEDREU  5
`define SBC_RESET_PC   32'h0000_0000
`define SBC_PC_STEP    32'h0000_0001
`define SBC_CTGT_RST   32'h0000_0000
`define SBC_IRQ_VEC    32'h0000_0000
`endif

// ---- hdl/sbc_cond_eval.v ----
`timescale 1ns/1ps
module sbc_cond_eval #(
	parameter NCOND = 4
) (
	input  wire [NCOND-1:0] x_flags,
	input  wire [NCOND-1:0] y_flags,
	input  wire [1:0]       csel,
	input  wire [1:0]       blk,
	input  wire             use_cond,
	output wire             cond_true
);
	wire x_bit;
	wire y_bit;
	reg  val;
	assign x_bit = x_flags[csel];
	assign y_bit = y_flags[csel];
	always @* begin
		case (blk)
		`SBC_B_X: val = x_bit;
		`SBC_B_Y: val = y_bit;
		default:  val = x_bit | y_bit;
		endcase
	end
	assign cond_true = ~use_cond | val;
endmodule // sbc_cond_eval

// ---- hdl/sbc_prio_mask.v ----
`timescale 1ns/1ps
module sbc_prio_mask #(
	parameter NIRQ = 8
) (
	input  wire            core_clk,
	input  wire            arst_n,
	input  wire [NIRQ-1:0] irq_req,
	input  wire            enter,
	input  wire            leave,
	input  wire            reduce,
	output reg  [NIRQ-1:0] priority_mask_reg,
	output reg  [NIRQ-1:0] svc_onehot_reg,
	output wire [NIRQ-1:0] block_mask
);
	// Lowest index is highest priority
	function [NIRQ-1:0] pick;
		input [NIRQ-1:0] v;
		integer i;
		begin
			pick = {NIRQ{1'b0}};
			for (i = NIRQ-1; i >= 0; i = i - 1)
				if (v[i])
					pick = {NIRQ{1'b0}} | ({{(NIRQ-1){1'b0}}, 1'b1} << i);
		end
	endfunction
	wire [NIRQ-1:0] win;
	wire [NIRQ-1:0] cur;
	assign win = pick(irq_req);
	assign cur = pick(priority_mask_reg);
	// Bits at or above the lowest in-service index are blocked
	genvar g;
	generate
		for (g = 0; g < NIRQ; g = g + 1) begin : g_blk
			if (g == 0) begin : g0
				assign block_mask[g] = cur[g];
			end else begin : gn
				assign block_mask[g] = cur[g] | block_mask[g-1];
			end
		end
	endgenerate
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			priority_mask_reg <= {NIRQ{1'b0}};
			svc_onehot_reg    <= {NIRQ{1'b0}};
		end else if (enter) begin
			priority_mask_reg <= priority_mask_reg | win;
			svc_onehot_reg    <= win;
		end else if (reduce) begin
			// Only the reduced level clears; preempted ones stay set
			priority_mask_reg <= priority_mask_reg & ~svc_onehot_reg;
		end else if (leave) begin
			priority_mask_reg <= priority_mask_reg & ~cur;
			svc_onehot_reg    <= {NIRQ{1'b0}};
		end
	end
endmodule // sbc_prio_mask

// ---- tb/sbc_branch_ctrl_asserts.sv ----
`timescale 1ns/1ps
`include "sbc_defs.vh"
module sbc_branch_ctrl_asserts (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        flush,
	input wire logic [2:0]  slot_exec,
	input wire logic        xfer_x_we,
	input wire logic        xfer_y_we
);
	// Cycles since the last accepted control write, saturating
	logic [2:0] since_reg;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			since_reg <= 3'h7;
		else if (psel && penable && pwrite && paddr == `SBC_A_CTRL)
			since_reg <= 3'h0;
		else if (since_reg != 3'h7)
			since_reg <= since_reg + 3'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_ready_one: assert property (psel |-> pready)
		else $error("pready low");
	a_no_error: assert property (psel && penable |-> !pslverr)
		else $error("pslverr raised");
	a_flush_cause: assert property (flush |-> since_reg <= 3'h3)
		else $error("flush without instruction");
	a_flush_pulse: assert property (flush |=> !flush)
		else $error("flush longer than one cycle");
	a_slot_cause: assert property (|slot_exec |-> since_reg <= 3'h2)
		else $error("slot enable without instruction");
	a_slot_pulse: assert property ($rose(|slot_exec) |=> !(|slot_exec))
		else $error("slot enable held");
	a_xfer_cause: assert property (xfer_x_we || xfer_y_we |-> since_reg <= 3'h2)
		else $error("transfer without instruction");
	a_xfer_pulse: assert property (xfer_x_we || xfer_y_we |=>
		!(xfer_x_we || xfer_y_we)) else $error("transfer held");
endmodule // sbc_branch_ctrl_asserts
bind sbc_branch_ctrl sbc_branch_ctrl_asserts u_chk (.core_clk(core_clk),
	.arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .flush(flush),
	.slot_exec(slot_exec), .xfer_x_we(xfer_x_we), .xfer_y_we(xfer_y_we));

// ---- tb/sbc_branch_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "sbc_defs.vh"
module sbc_branch_ctrl_tb;
	localparam logic [31:0] all_m = 32'hffff_ffff;
	logic        core_clk, arst_n, psel, penable, pwrite;
	logic        pready, pslverr, flush, xfer_x_we, xfer_y_we;
	logic        tk, np, ab, ce;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, fetch_pc, pc_m, ct_m, r, v;
	logic [31:0] seed = 32'h3c;
	logic [3:0]  external_irq_pins;
	logic [7:0]  internal_irq, fl;
	logic [2:0]  slot_exec, sl, seen;
	logic [1:0]  bk, cs;
	logic [15:0] im;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          i;
	sbc_branch_ctrl dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.external_irq_pins(external_irq_pins), .internal_irq(internal_irq),
		.fetch_pc(fetch_pc), .flush(flush), .slot_exec(slot_exec),
		.xfer_x_we(xfer_x_we), .xfer_y_we(xfer_y_we));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Remembers pulses seen since the last instruction
	always @(posedge core_clk) begin
		if (flush) seen[0] = 1'b1;
		if (xfer_x_we) seen[1] = 1'b1;
		if (xfer_y_we) seen[2] = 1'b1;
		if (slot_exec != 3'h0) sl = slot_exec;
	end
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [31:0] cw(input logic [2:0] k, input logic [2:0] g);
		return {im, 2'b00, g, 1'b0, cs, bk, ce, ab, np, k};
	endfunction
	function logic cv();
		return !ce || (bk == `SBC_B_X ? fl[cs] : bk == `SBC_B_Y ? fl[4+cs]
			: fl[cs] | fl[4+cs]);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, r & m);
	endtask
	task automatic ex(input logic [31:0] c);
		seen = 3'h0;
		sl = 3'h0;
		apb(1'b1, `SBC_A_CTRL, c);
		repeat (4) @(posedge core_clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{external_irq_pins, internal_irq, pc_m, ct_m} = '0;
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd("ctgt", `SBC_A_CTGT, all_m, `SBC_CTGT_RST);
		rd("unmapped", 12'h100, all_m, 32'h0);
		for (i = 0; i < 30; i++) begin
			v = xs();
			{im, fl, cs, bk, ce, ab, np} = {v[31:8], v[6:5], 2'(v[4:3] % 3), v[2:0]};
			if (i == 0) {im, ab} = {16'h8000, 1'b1};
			apb(1'b1, `SBC_A_FLAGS, {24'h0, fl});
			tk = cv();
			ex(cw(v[7] ? `SBC_K_CALL : `SBC_K_JUMP, 3'h0));
			if (tk && v[7]) ct_m = pc_m + `SBC_PC_STEP;
			pc_m = !tk ? pc_m + `SBC_PC_STEP : ab ? {16'h0, im}
				: pc_m + {{16{im[15]}}, im};
			chk("pc", pc_m, fetch_pc);
			chk("flush", {31'h0, tk == np}, {31'h0, seen[0]});
			rd("ctgt", `SBC_A_CTGT, all_m, ct_m);
		end
		v = xs();
		apb(1'b1, `SBC_A_INTEGER_UNIT, v);
		rd("ctgt", `SBC_A_CTGT, all_m, v);
		{np, ab, ce, im} = {3'b010, 16'h0};
		ex(cw(`SBC_K_CJMP, 3'h0));
		chk("pc", v, fetch_pc);
		pc_m = xs();
		apb(1'b1, `SBC_A_INTEGER_UNIT, pc_m);
		ex(cw(`SBC_K_CCALL, 3'h0));
		chk("pc", pc_m, fetch_pc);
		rd("ctgt", `SBC_A_CTGT, all_m, v + `SBC_PC_STEP);
		for (i = 0; i < 6; i++) begin
			v = xs();
			{bk, ce, cs, fl} = {2'(i % 3), i > 2, v[1:0], v[15:8]};
			apb(1'b1, `SBC_A_FLAGS, {24'h0, fl});
			ex(cw(`SBC_K_NONE, v[4:2]));
			chk("slots", cv() ? 7 : {29'h0, ~v[4:2]}, {29'h0, sl});
			if (!ce) chk("xfer", {bk != `SBC_B_X, bk != `SBC_B_Y}, seen[2:1]);
		end
		{ab, ce} = 2'b00;
		ex(cw(`SBC_K_CCALL, 3'h0));
		rd("illegal", `SBC_A_STATUS, 32'h4, 32'h4);
		ex(cw(`SBC_K_RETURN_REUSABLE, 3'h0));
		rd("illegal", `SBC_A_STATUS, 32'h4, 32'h4);
		ex(cw(`SBC_K_RTI, 3'h0));
		rd("illegal", `SBC_A_STATUS, 32'h4, 32'h4);
		// One-cycle request so the level does not re-pend after reduce
		external_irq_pins <= 4'h2;
		@(posedge core_clk);
		external_irq_pins <= 4'h0;
		repeat (3) @(posedge core_clk);
		rd("insvc", `SBC_A_RESULT, 32'hff, 32'h2);
		rd("status", `SBC_A_STATUS, 32'h8, 32'h8);
		ab = 1'b1;
		ex(cw(`SBC_K_REDUCE, 3'h0));
		rd("reduced", `SBC_A_STATUS, 32'h10, 32'h10);
		ex(cw(`SBC_K_RTI, 3'h0));
		rd("misuse", `SBC_A_STATUS, 32'h20, 32'h20);
		stop_test();
	end
endmodule // sbc_branch_ctrl_tb
